// ### dcm_defines.vh
/*
 * Constants of the drive command and mode selector: register indices,
 * field positions, reset values, mode codes and scaling figures.
 * Assumes inclusion by bare name from the selector's design files.
 */
`ifndef DCM_DEFINES_VH
`define DCM_DEFINES_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define DCM_IDX_FULL_SCALE   12'h152
`define DCM_IDX_MODE         12'h101
`define DCM_IDX_STATUS       12'h180
`define DCM_IDX_W            12

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define DCM_FULL_SCALE_RST   16'h0064
`define DCM_FULL_SCALE_MAX   16'h03E8
`define DCM_MODE_RST         8'h00

// ****************************************************************
// Scaling: input in millivolts, torque out in hundredths of a percent
// ****************************************************************
`define DCM_VIN_MAX_V        10
`define DCM_MV_PER_V         1000
`define DCM_CENTI_PER_PCT    100

// ****************************************************************
// Control mode codes
// ****************************************************************
`define DCM_CODE_PT          8'h00
`define DCM_CODE_PR          8'h01
`define DCM_CODE_S           8'h02
`define DCM_CODE_T           8'h03
`define DCM_CODE_SZ          8'h04
`define DCM_CODE_TZ          8'h05
`define DCM_CODE_PT_S        8'h06
`define DCM_CODE_PT_T        8'h07
`define DCM_CODE_PR_S        8'h08
`define DCM_CODE_PR_T        8'h09
`define DCM_CODE_S_T         8'h0A
`define DCM_CODE_PULSE_OR_STORED_DUAL       8'h0D
`define DCM_CODE_POSITION_OR_SPEED_MULTI     8'h0E
`define DCM_CODE_POSITION_OR_TORQUE_MULTI     8'h0F

// ****************************************************************
// Active operating mode encoding
// ****************************************************************
`define DCM_ACT_POS          2'h0
`define DCM_ACT_SPEED        2'h1
`define DCM_ACT_TORQUE       2'h2

// ****************************************************************
// Status register field positions
// ****************************************************************
`define DCM_ST_ACT_LSB       0
`define DCM_ST_STORED        2
`define DCM_ST_HOLD          3
`define DCM_ST_TGT_LSB       4
`define DCM_ST_SERVO         10
`define DCM_ST_TSEL_LSB      11

// ****************************************************************
// AXI responses
// ****************************************************************
`define DCM_RESP_OKAY        2'h0
`define DCM_RESP_SLVERR      2'h2

`endif

// ### dcm_sync.v
/*
 * Three-stage input synchroniser with agreement filter, one lane per bit.
 * Assumes asynchronous inputs and a single clock with a freezing enable.
 */
`timescale 1ns/1ps

module dcm_sync #(
  parameter W = 1
) (
  // Clock and control
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         ce,
  // Data
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_lane
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          out_q <= 1'b0;
        end else if (ce) begin
          s1_q <= d[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Change accepted only when the last two stages agree
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign q[i] = out_q;
    end
  endgenerate

endmodule // dcm_sync

// ### dcm_top.v
/*
 * Command and mode selector of a servo drive: analog torque scaling,
 * single, dual and multiple control mode selection, trigger-latched
 * position targets, AXI4-Lite register access.
 * Assumes digital mode inputs arrive asynchronously from an external
 * controller; the analog sample and preset values are on aclk.
 */
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "dcm_defines.vh"

// How it works
// R1 - Full scale sets torque at 10 V
// R2 - Same full scale sets torque limit elsewhere
// R3 - Torque equals volts times full scale over ten
// R4 - Full scale 16 bit, 0..1000, default 100
// R5 - Zero variant zeroes first source, else analog
// R6 - Selected torque honoured only after servo enable
// R7 - Decode dual codes 06..0A into pairs
// R8 - Decode 0D, 0E, 0F position multi selections
// R9 - No zero variants in dual or multi modes
// R10 - Speed switch on: speed, trigger ignored
// R11 - Switch off: hold stopped until trigger rise
// R12 - Trigger rise latches target, starts move
// R13 - Switch back on returns to speed at once
// R14 - Pulse or stored table feeds position command
// R15 - Torque switch on: torque by torque selects
// R16 - Torque switch off: speed follows at once
// R17 - Torque switch on again: torque at once
// R18 - Nonzero torque selects pick internal preset
// R19 - Preset applied only after select change
// R20 - Inputs synchronised, trigger edge by samples
// R21 - Controller holds selects stable before trigger
module dcm_top (
  // Clock, reset, enable
  input  wire               aclk,
  input  wire               aresetn,
  input  wire               ce,
  // AXI4-Lite write address
  input  wire [13:0]        s_axi_awaddr,
  input  wire [2:0]         s_axi_awprot,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]         s_axi_bresp,
  output wire               s_axi_bvalid,
  input  wire               s_axi_bready,
  // AXI4-Lite read address
  input  wire [13:0]        s_axi_araddr,
  input  wire [2:0]         s_axi_arprot,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0]        s_axi_rdata,
  output wire [1:0]         s_axi_rresp,
  output wire               s_axi_rvalid,
  input  wire               s_axi_rready,
  // Digital inputs from the motion controller
  input  wire               servo_on,
  input  wire               speed_pos_switch,
  input  wire               speed_torque_switch,
  input  wire               torque_pos_switch,
  input  wire               pos_stored_switch,
  input  wire [1:0]         torque_select_inputs,
  input  wire [1:0]         speed_select_inputs,
  input  wire [5:0]         position_select_inputs,
  input  wire               position_trigger,
  // Analog sample and internal torque presets
  input  wire signed [15:0] analog_torque_mv,
  input  wire signed [15:0] torque_preset_1,
  input  wire signed [15:0] torque_preset_2,
  input  wire signed [15:0] torque_preset_3,
  // Command outputs
  output wire [1:0]         active_mode,
  output wire               pos_from_table,
  output wire               motor_hold,
  output wire [5:0]         target_index,
  output wire               target_start,
  output wire [1:0]         speed_cmd_select,
  output wire signed [23:0] torque_cmd,
  output wire               torque_is_limit
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  wire [15:0] pins_s;

  dcm_sync #(
    .W (16)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({servo_on, speed_pos_switch, speed_torque_switch,
                torque_pos_switch, pos_stored_switch, torque_select_inputs,
                speed_select_inputs, position_select_inputs,
                position_trigger}), // R20
    .q       (pins_s)
  );

  wire       srv_s   = pins_s[15];
  wire       sp_s    = pins_s[14];
  wire       st_s    = pins_s[13];
  wire       tp_s    = pins_s[12];
  wire       ps_s    = pins_s[11];
  wire [1:0] tsel_s  = pins_s[10:9];
  wire [1:0] ssel_s  = pins_s[8:7];
  wire [5:0] psel_s  = pins_s[6:1];
  wire       trig_s  = pins_s[0];

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [15:0] full_scale_q;
  reg [7:0]  mode_code_q;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  // Result: {needs_trigger, zero_speed, zero_torque, stored, act[1:0]}
  function [5:0] decode_mode;
    input [7:0] code;
    input       sp;
    input       st;
    input       tp;
    input       ps;
    begin
      case (code)
        `DCM_CODE_PT:      decode_mode = {4'b0000, `DCM_ACT_POS};
        `DCM_CODE_PR:      decode_mode = {4'b0001, `DCM_ACT_POS};
        `DCM_CODE_S:       decode_mode = {4'b0000, `DCM_ACT_SPEED};
        `DCM_CODE_T:       decode_mode = {4'b0000, `DCM_ACT_TORQUE};
        `DCM_CODE_SZ:      decode_mode = {4'b0100, `DCM_ACT_SPEED};
        `DCM_CODE_TZ:      decode_mode = {4'b0010, `DCM_ACT_TORQUE}; // R5
        // Dual and multi codes never carry zero variants
        `DCM_CODE_PT_S:    decode_mode = sp ? {4'b1000, `DCM_ACT_SPEED}
                                            : {4'b1000, `DCM_ACT_POS}; // R7 R9 R10 R13
        `DCM_CODE_PT_T:    decode_mode = tp ? {4'b1000, `DCM_ACT_TORQUE}
                                            : {4'b1000, `DCM_ACT_POS}; // R7 R9
        `DCM_CODE_PR_S:    decode_mode = sp ? {4'b1001, `DCM_ACT_SPEED}
                                            : {4'b1001, `DCM_ACT_POS}; // R7 R14
        `DCM_CODE_PR_T:    decode_mode = tp ? {4'b1001, `DCM_ACT_TORQUE}
                                            : {4'b1001, `DCM_ACT_POS}; // R7 R14
        `DCM_CODE_S_T:     decode_mode = st ? {4'b0000, `DCM_ACT_TORQUE}
                                            : {4'b0000, `DCM_ACT_SPEED}; // R7 R15 R16 R17
        `DCM_CODE_PULSE_OR_STORED_DUAL:   decode_mode = {3'b000, ps, `DCM_ACT_POS}; // R8 R14
        `DCM_CODE_POSITION_OR_SPEED_MULTI: decode_mode = sp ? {4'b1000, `DCM_ACT_SPEED}
                                            : {3'b100, ps, `DCM_ACT_POS}; // R8
        `DCM_CODE_POSITION_OR_TORQUE_MULTI: decode_mode = tp ? {4'b1000, `DCM_ACT_TORQUE}
                                            : {3'b100, ps, `DCM_ACT_POS}; // R8
        // Unknown code falls back to plain speed
        default:           decode_mode = {4'b0000, `DCM_ACT_SPEED};
      endcase
    end
  endfunction

  wire [5:0] dec      = decode_mode(mode_code_q, sp_s, st_s, tp_s, ps_s);
  wire [1:0] act      = dec[1:0];
  wire       stored   = dec[2];
  wire       zero_t   = dec[3];
  wire       zero_s   = dec[4];
  wire       need_trg = dec[5];
  wire       in_pos   = (act == `DCM_ACT_POS);

  // ****************************************************************
  // Position trigger and target latch
  // ****************************************************************
  reg        trig_prev_q;
  reg        hold_q;
  reg [5:0]  target_q;
  reg        start_q;

  wire trig_rise = trig_s & ~trig_prev_q; // R20

  always @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev_q <= 1'b0;
      hold_q      <= 1'b1;
      target_q    <= 6'h00;
      start_q     <= 1'b0;
    end else if (ce) begin
      trig_prev_q <= trig_s;
      start_q     <= 1'b0;
      if (!in_pos) begin
        // Trigger is ignored outside position mode; rearm the hold
        hold_q <= 1'b1; // R10 R13
      end else if (trig_rise) begin
        // Target sampled here: selects must already be settled
        target_q <= psel_s; // R12 R21
        start_q  <= 1'b1; // R12
        hold_q   <= 1'b0; // R11
      end
    end
  end

  // ****************************************************************
  // Torque source selection
  // ****************************************************************
  reg [1:0] tsel_prev_q;
  reg [1:0] tsel_applied_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      tsel_prev_q    <= 2'h0;
      tsel_applied_q <= 2'h0;
    end else if (ce) begin
      tsel_prev_q <= tsel_s;
      if (tsel_s != tsel_prev_q) begin
        tsel_applied_q <= tsel_s; // R19
      end
    end
  end

  // Product needs 33 bits: 16-bit signed sample times 17-bit signed full scale
  wire signed [32:0] scaled_prod = analog_torque_mv * $signed({1'b0, full_scale_q});
  // mV*pct/(10 V*1000 mV/V) percent, kept in hundredths of a percent
  wire signed [32:0] scale_div =
    $signed((`DCM_VIN_MAX_V * `DCM_MV_PER_V) / `DCM_CENTI_PER_PCT);
  wire signed [32:0] analog_centi = scaled_prod / scale_div; // R1 R2 R3

  reg signed [15:0] preset_pct;
  always @* begin
    case (tsel_applied_q)
      2'h1:    preset_pct = torque_preset_1;
      2'h2:    preset_pct = torque_preset_2;
      2'h3:    preset_pct = torque_preset_3;
      default: preset_pct = 16'sh0000;
    endcase
  end

  wire signed [23:0] preset_centi = preset_pct * $signed(24'sd100);

  reg signed [23:0] torque_d;
  always @* begin
    if (!srv_s) begin
      torque_d = 24'sh000000; // R6
    end else if (tsel_applied_q != 2'h0) begin
      torque_d = preset_centi; // R18
    end else if (zero_t) begin
      torque_d = 24'sh000000; // R5
    end else begin
      torque_d = analog_centi[23:0]; // R5 R18
    end
  end

  reg signed [23:0] torque_q;
  reg               limit_q;
  reg [1:0]         act_q;
  reg               stored_q;
  reg               hold_out_q;
  reg [1:0]         ssel_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      torque_q   <= 24'sh000000;
      limit_q    <= 1'b0;
      act_q      <= `DCM_ACT_POS;
      stored_q   <= 1'b0;
      hold_out_q <= 1'b1;
      ssel_q     <= 2'h0;
    end else if (ce) begin
      torque_q   <= torque_d;
      limit_q    <= (act != `DCM_ACT_TORQUE); // R2
      act_q      <= act;
      stored_q   <= stored; // R14
      hold_out_q <= in_pos & need_trg & hold_q & ~trig_rise; // R11
      // Zero speed variant never passes a select through
      ssel_q     <= (act == `DCM_ACT_SPEED && !zero_s) ? ssel_s : 2'h0; // R10 R16
    end
  end

  assign torque_cmd       = torque_q;
  assign torque_is_limit  = limit_q;
  assign active_mode      = act_q;
  assign pos_from_table   = stored_q;
  assign motor_hold       = hold_out_q;
  assign target_index     = target_q;
  assign target_start     = start_q;
  assign speed_cmd_select = ssel_q;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  reg                  aw_have_q;
  reg [`DCM_IDX_W-1:0] aw_idx_q;
  reg                  w_have_q;
  reg [31:0]           wdata_q;
  reg [3:0]            wstrb_q;
  reg                  bvalid_q;
  reg [1:0]            bresp_q;
  reg                  rvalid_q;
  reg [1:0]            rresp_q;
  reg [31:0]           rdata_q;

  // Ready only while idle, so a single write and a single read at a time
  assign s_axi_awready = ce & ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ce & ~w_have_q & ~bvalid_q;
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  wire        aw_take = s_axi_awvalid & s_axi_awready;
  wire        w_take  = s_axi_wvalid & s_axi_wready;
  wire        do_wr   = aw_have_q & w_have_q & ~bvalid_q;
  wire [15:0] fs_new  = {wstrb_q[1] ? wdata_q[15:8] : full_scale_q[15:8],
                         wstrb_q[0] ? wdata_q[7:0]  : full_scale_q[7:0]};
  wire [7:0]  md_new  = wstrb_q[0] ? wdata_q[7:0] : mode_code_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      aw_idx_q     <= {`DCM_IDX_W{1'b0}};
      w_have_q     <= 1'b0;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      bvalid_q     <= 1'b0;
      bresp_q      <= `DCM_RESP_OKAY;
      full_scale_q <= `DCM_FULL_SCALE_RST; // R4
      mode_code_q  <= `DCM_MODE_RST;
    end else if (ce) begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[13:2];
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= `DCM_RESP_OKAY;
        case (aw_idx_q)
          `DCM_IDX_FULL_SCALE: begin
            // Out of range value refused, old value kept
            if (fs_new > `DCM_FULL_SCALE_MAX) begin
              bresp_q <= `DCM_RESP_SLVERR; // R4
            end else begin
              full_scale_q <= fs_new; // R4
            end
          end
          `DCM_IDX_MODE: begin
            mode_code_q <= md_new;
          end
          default: begin
            bresp_q <= `DCM_RESP_SLVERR;
          end
        endcase
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  wire [31:0] status_word = {19'h00000, tsel_applied_q, srv_s, target_q,
                             hold_out_q, stored_q, act_q};

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `DCM_RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rresp_q  <= `DCM_RESP_OKAY;
        case (s_axi_araddr[13:2])
          `DCM_IDX_FULL_SCALE: rdata_q <= {16'h0000, full_scale_q};
          `DCM_IDX_MODE:       rdata_q <= {24'h000000, mode_code_q};
          `DCM_IDX_STATUS:     rdata_q <= status_word;
          default: begin
            rdata_q <= 32'h00000000;
            rresp_q <= `DCM_RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule // dcm_top

// ### dcm_monitor.sv
/* Checker of the selector ports: bus answers, trigger latch, hold and torque.
   Assumes a bind onto dcm_top and the single aclk domain. */
`timescale 1ns/1ps
`include "dcm_defines.vh"
module dcm_monitor (
  // Clock and reset
  input wire               aclk,
  input wire               aresetn,
  // Bus handshakes
  input wire               s_axi_awvalid,
  input wire               s_axi_awready,
  input wire               s_axi_wvalid,
  input wire               s_axi_wready,
  input wire               s_axi_bvalid,
  input wire               s_axi_bready,
  input wire [1:0]         s_axi_bresp,
  input wire               s_axi_arvalid,
  input wire               s_axi_arready,
  input wire               s_axi_rvalid,
  input wire               s_axi_rready,
  input wire [31:0]        s_axi_rdata,
  // Pins and commands
  input wire               servo_on,
  input wire [1:0]         active_mode,
  input wire               motor_hold,
  input wire               target_start,
  input wire signed [23:0] torque_cmd,
  input wire               torque_is_limit
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_start_pulse: assert property (target_start |=> !target_start)
    else $error("target start longer than one cycle");
  a_start_in_pos: assert property (target_start |-> active_mode == `DCM_ACT_POS)
    else $error("target latched outside position mode");
  a_start_ends_hold: assert property (target_start |-> !motor_hold)
    else $error("hold not released on target latch");
  a_hold_only_pos: assert property (motor_hold |-> active_mode == `DCM_ACT_POS)
    else $error("hold outside position mode");
  a_torque_not_limit: assert property (active_mode == `DCM_ACT_TORQUE |-> !torque_is_limit)
    else $error("torque mode flagged as limit");
  a_servo_off_zero: assert property ((!servo_on) [*8] |-> torque_cmd == 24'h000000)
    else $error("torque while servo off");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // dcm_monitor

bind dcm_top dcm_monitor u_mon (.*);

// ### dcm_ctrl_model.sv
/* Motion controller model: drives servo enable, mode switches, selects, trigger.
   Assumes calls from the bench; every change lands just after a rising edge. */
`timescale 1ns/1ps
module dcm_ctrl_model (
  // Clock
  input  wire        aclk,
  // Digital outputs toward the drive
  output logic       servo_on = 1'b0,
  output logic       speed_pos_switch = 1'b0,
  output logic       speed_torque_switch = 1'b0,
  output logic       torque_pos_switch = 1'b0,
  output logic       pos_stored_switch = 1'b0,
  output logic [1:0] torque_select_inputs = 2'h0,
  output logic [1:0] speed_select_inputs = 2'h0,
  output logic [5:0] position_select_inputs = 6'h00,
  output logic       position_trigger = 1'b0
);
  task set_modes(input logic sv, sp, st, tp, ps);
    @(posedge aclk);
    servo_on <= sv;
    speed_pos_switch <= sp;
    speed_torque_switch <= st;
    torque_pos_switch <= tp;
    pos_stored_switch <= ps;
  endtask
  task set_sel(input logic [1:0] ts, input logic [1:0] ss, input logic [5:0] ps);
    @(posedge aclk);
    torque_select_inputs <= ts;
    speed_select_inputs <= ss;
    position_select_inputs <= ps;
  endtask
  // Selects settle well before the trigger rises
  task pulse_trigger;
    repeat (6) @(posedge aclk);
    position_trigger <= 1'b1;
    repeat (8) @(posedge aclk);
    position_trigger <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
endmodule // dcm_ctrl_model

// ### tb_dcm_top.sv
/* Self-checking bench of the selector: register access, scaling, mode pairs.
   Assumes dcm_top, the controller model and the bound checker. */
`timescale 1ns/1ps
`include "dcm_defines.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_dcm_top;
  // ****
  // Signals
  // ****
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, active_mode, speed_cmd_select;
  wire [31:0] s_axi_rdata;
  wire servo_on, speed_pos_switch, speed_torque_switch, torque_pos_switch, pos_stored_switch;
  wire [1:0] torque_select_inputs, speed_select_inputs;
  wire [5:0] position_select_inputs, target_index;
  wire position_trigger, pos_from_table, motor_hold, target_start, torque_is_limit;
  wire signed [23:0] torque_cmd;
  logic signed [15:0] analog_torque_mv = 16'sh0000, torque_preset_1 = 16'sh0014;
  logic signed [15:0] torque_preset_2 = -16'sh001E, torque_preset_3 = 16'sh012C;
  int fails = 0, n_compared = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  localparam logic [13:0] A_FS = {`DCM_IDX_FULL_SCALE, 2'b00};
  localparam logic [13:0] A_MD = {`DCM_IDX_MODE, 2'b00};
  logic [7:0] codes[8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0D, 8'h0E, 8'h0F};
  logic [1:0] m_on[8] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2};
  logic [1:0] m_off[8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
  logic st_off[8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic hold_off[8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  dcm_top u_dut (.*);
  dcm_ctrl_model u_ctrl (.*);
  always #2 aclk = ~aclk;

  // ****
  // Tasks
  // ****
  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task timeout(input logic ok);
    if (!ok) begin
      fails++;
      $display("Error bus wait expected answer seen none");
      give_verdict;
    end
  endtask
  task axi_wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    logic aw_ok, w_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    for (i = 0; i < 50 && !(aw_ok && w_ok); i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin aw_ok = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wvalid && s_axi_wready) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    timeout(aw_ok && w_ok);
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    i = 0;
    do begin @(posedge aclk); i++; end while (s_axi_bvalid !== 1'b1 && i < 50);
    s_axi_bready <= 1'b0;
    timeout(s_axi_bvalid === 1'b1);
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task axi_rd(input logic [13:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    i = 0;
    do begin @(posedge aclk); i++; end while (s_axi_arready !== 1'b1 && i < 50);
    s_axi_arvalid <= 1'b0;
    timeout(s_axi_arready === 1'b1);
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    i = 0;
    do begin @(posedge aclk); i++; end while (s_axi_rvalid !== 1'b1 && i < 50);
    s_axi_rready <= 1'b0;
    timeout(s_axi_rvalid === 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // Pins pass a synchroniser
  task settle;
    repeat (8) @(posedge aclk);
  endtask
  function automatic logic signed [23:0] scal(input int mv, input int fs);
    return 24'((mv * fs * `DCM_CENTI_PER_PCT) / (`DCM_MV_PER_V * `DCM_VIN_MAX_V));
  endfunction

  // ****
  // Sequence
  // ****
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(A_FS); `CHK("fs_reset", 32'h00000064, rd)
    axi_wr(A_FS, 32'h000003E9, `DCM_RESP_SLVERR);
    axi_wr(A_FS, 32'h000003E8, `DCM_RESP_OKAY);
    axi_rd(A_FS); `CHK("fs_max", 32'h000003E8, rd)
    axi_rd(14'h0010); `CHK("unmapped", `DCM_RESP_SLVERR, rsp)
    axi_wr(A_MD, 32'h00000003, `DCM_RESP_OKAY);
    u_ctrl.set_modes(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    analog_torque_mv <= -16'sd10000;
    settle; `CHK("t_min", scal(-10000, 1000), torque_cmd)
    axi_wr(A_FS, 32'h000000C8, `DCM_RESP_OKAY);
    analog_torque_mv <= 16'sd5000;
    settle; `CHK("t_half", scal(5000, 200), torque_cmd)
    `CHK("t_flag", 1'b0, torque_is_limit)
    axi_wr(A_MD, 32'h00000005, `DCM_RESP_OKAY);
    settle; `CHK("t_zero", 24'h000000, torque_cmd)
    u_ctrl.set_sel(2'h2, 2'h0, 6'h00);
    settle; `CHK("t_preset", 24'(torque_preset_2 * 100), torque_cmd)
    u_ctrl.set_modes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    settle; `CHK("t_off", 24'h000000, torque_cmd)
    axi_wr(A_MD, 32'h00000002, `DCM_RESP_OKAY);
    u_ctrl.set_sel(2'h0, 2'h1, 6'h00);
    u_ctrl.set_modes(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    settle; `CHK("lim_val", scal(5000, 200), torque_cmd)
    `CHK("lim_flag", 1'b1, torque_is_limit)
    for (int k = 0; k < 8; k++) begin
      axi_wr(A_MD, {24'h0, codes[k]}, `DCM_RESP_OKAY);
      u_ctrl.set_modes(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
      settle; `CHK("mode_on", m_on[k], active_mode)
      u_ctrl.set_modes(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      settle; `CHK("mode_off", m_off[k], active_mode)
      `CHK("hold", hold_off[k], motor_hold)
      if (m_off[k] == `DCM_ACT_POS) `CHK("source", st_off[k], pos_from_table)
    end
    axi_wr(A_MD, 32'h00000008, `DCM_RESP_OKAY);
    u_ctrl.set_sel(2'h0, 2'h3, 6'h2A);
    u_ctrl.set_modes(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    settle;
    u_ctrl.pulse_trigger;
    `CHK("sp_sel", 2'h3, speed_cmd_select)
    `CHK("no_latch", 6'h00, target_index)
    u_ctrl.set_modes(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    settle; `CHK("wait_hold", 1'b1, motor_hold)
    u_ctrl.pulse_trigger;
    `CHK("target", 6'h2A, target_index)
    `CHK("moving", 1'b0, motor_hold)
    `CHK("table", 1'b1, pos_from_table)
    u_ctrl.set_modes(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    settle; `CHK("back_speed", `DCM_ACT_SPEED, active_mode)
    give_verdict;
  end
endmodule // tb_dcm_top
